/* core/dhcp_pkg.sv */
package dhcp_pkg;
    // ---------------------------------------------------------------
    // Command codes
    // ---------------------------------------------------------------
    localparam logic [7:0] OP_READ = 8'h00;
    localparam logic [7:0] OP_WRITE = 8'h01;
    localparam logic [7:0] OP_WRITE_VERIFY = 8'h02;
    localparam logic [3:0] TYPE_DIAG = 4'h1;
    localparam logic [3:0] TYPE_SYS = 4'h2;
    localparam logic [23:0] LBA_IDENT = 24'hffffff;
    localparam logic [23:0] LBA_SPARE = 24'hfffffe;
    localparam int LEGACY_BYTES = 4;
    localparam logic [2:0] LEGACY_LAST = 3'h3;
    localparam logic [3:0] MAX_FRAME = 4'hf;
    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int EXEC_NS = 100;
    localparam int CLK_NS = 10;
    localparam logic [7:0] EXEC_CYC = 8'(EXEC_NS / CLK_NS);
    localparam logic [7:0] WATCHDOG_CYC = 8'hff;
    // ---------------------------------------------------------------
    // Decoded operation
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        DHCP_OP_NONE,
        DHCP_OP_READ,
        DHCP_OP_WRITE,
        DHCP_OP_WRVER,
        DHCP_OP_IDENT,
        DHCP_OP_SPARE,
        DHCP_OP_DIAG,
        DHCP_OP_REJECT
    } dhcp_op_t;
endpackage : dhcp_pkg

/* core/dhcp_if.sv */
`timescale 1ns/1ps
interface dhcp_if;
    logic [7:0] host_data;
    logic host_data_oe;
    logic [7:0] ctrl_data;
    logic ctrl_data_oe;
    logic parity;
    logic host_attention;
    logic controller_hold_off;
    logic host_data_valid;
    logic read_not_write;
    wire [7:0] bus = ctrl_data_oe ? ctrl_data : (host_data_oe ? host_data : 8'h00);
    modport device (
        input host_data, host_data_oe, host_attention, host_data_valid, read_not_write,
        output ctrl_data, ctrl_data_oe, parity, controller_hold_off
    );
    modport host (
        input ctrl_data, ctrl_data_oe, parity, controller_hold_off,
        output host_data, host_data_oe, host_attention, host_data_valid, read_not_write
    );
endinterface : dhcp_if

/* core/dhcp_device.sv */
// Summary of operation
// - Controller drives odd parity on its words.
// - Host words unchecked; parity regenerated and returned.
// - Host checks parity on the line.
// - Host waits on hold-off before attention.
// - Hold-off asserted while controller is occupied.
// - Host strobe marks valid bus data.
// - Direction low writes, high reads.
// - Legacy opcodes read, write, write-verify.
// - Opcode plus three address bytes; extras ignored.
// - All-ones reads identity; minus one reads spares.
// - Self-test failure rejects block commands, not diagnostics.
// - Frame is lead, instruction, parameters, check.
// - Lead type nibble selects diagnostic or system.
// - Length nibble only feeds checksum.
// - Check byte is ones-complement of byte sum.
`timescale 1ns/1ps
module dhcp_device
    import dhcp_pkg::*;
(
    input wire logic mclk,
    input wire logic arst_n,
    dhcp_if.device link,
    input wire logic self_test_fail,
    input wire logic [7:0] result_byte,
    output logic cmd_valid_q,
    output dhcp_op_t cmd_op_q,
    output logic [23:0] cmd_lba_q,
    output logic [7:0] cmd_instr_q,
    output logic result_rd_q
);
    typedef enum logic [1:0] {IDLE, RECV, EXEC} dhcp_state_t;
    dhcp_state_t state_q;
    logic [7:0] buf_q [0:15];
    logic [3:0] cnt_q;
    logic [7:0] sum_q;
    logic [7:0] exec_q;
    logic stb_q;
    logic [7:0] ctrl_data_q;
    logic ctrl_oe_q;
    logic parity_q;
    logic hold_q;
    // ---------------------------------------------------------------
    // Decode
    // ---------------------------------------------------------------
    wire stb_rise = link.host_data_valid & ~stb_q;
    wire wr_stb = stb_rise & ~link.read_not_write;
    wire rd_stb = stb_rise & link.read_not_write;
    wire [3:0] lead_type = buf_q[0][7:4];
    wire framed = (lead_type == TYPE_DIAG) || (lead_type == TYPE_SYS);
    wire legacy = ~framed && (buf_q[0] <= OP_WRITE_VERIFY);
    wire [23:0] legacy_lba = {buf_q[1], buf_q[2], buf_q[3]};
    // The frame ends on the last byte written; the length nibble plays no part.
    wire [3:0] last_idx = cnt_q - 4'h1;
    wire [7:0] frame_sum = sum_q - buf_q[last_idx];
    wire check_ok = (buf_q[last_idx] == ~frame_sum);
    wire [7:0] sys_instr = buf_q[1];
    wire legacy_full = legacy && (cnt_q >= 4'(LEGACY_BYTES));
    wire frame_full = framed && (cnt_q >= 4'h3) && check_ok;
    // Diagnostic frames pass even after a failed self-test.
    wire frame_diag = (lead_type == TYPE_DIAG);
    wire lba_ident = (legacy_lba == LBA_IDENT);
    wire lba_spare = (legacy_lba == LBA_SPARE);
    wire lead_read = (buf_q[0] == OP_READ);
    wire lead_write = (buf_q[0] == OP_WRITE);
    wire instr_read = (sys_instr == OP_READ);
    wire instr_write = (sys_instr == OP_WRITE);
    wire instr_wrver = (sys_instr == OP_WRITE_VERIFY);
    dhcp_op_t op_d;
    // Anything that is neither a whole legacy command nor a clean frame falls through to a refusal,
    // so a short or garbled command can never start a transfer.
    always_comb begin
        op_d = DHCP_OP_REJECT;
        if (legacy_full) begin
            if (self_test_fail) begin
                op_d = DHCP_OP_REJECT;
            end else if (lead_read && lba_ident) begin
                op_d = DHCP_OP_IDENT;
            end else if (lead_read && lba_spare) begin
                op_d = DHCP_OP_SPARE;
            end else if (lead_read) begin
                op_d = DHCP_OP_READ;
            end else if (lead_write) begin
                op_d = DHCP_OP_WRITE;
            end else begin
                op_d = DHCP_OP_WRVER;
            end
        end else if (frame_full) begin
            if (frame_diag) begin
                op_d = DHCP_OP_DIAG;
            end else if (self_test_fail) begin
                op_d = DHCP_OP_REJECT;
            end else if (instr_read) begin
                op_d = DHCP_OP_READ;
            end else if (instr_write) begin
                op_d = DHCP_OP_WRITE;
            end else if (instr_wrver) begin
                op_d = DHCP_OP_WRVER;
            end
        end
    end
    // ---------------------------------------------------------------
    // Receive buffer
    // ---------------------------------------------------------------
    // Bytes beyond the fifteenth are dropped; legacy decode only looks at the first four.
    // The entries carry no reset: the decoded operation only depends on entries below the byte count.
    wire byte_take = (state_q == RECV) && wr_stb && (cnt_q != MAX_FRAME);
    always_ff @(posedge mclk) begin
        if (byte_take) begin
            buf_q[cnt_q] <= link.host_data;
        end
    end
    // ---------------------------------------------------------------
    // Strobe edge
    // ---------------------------------------------------------------
    // Only the rising edge counts, so a strobe held high takes one byte and not one per cycle.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            stb_q <= 1'b0;
        end else begin
            stb_q <= link.host_data_valid;
        end
    end
    wire frame_end = !link.host_attention;
    wire exec_done = (exec_q == 8'h00);
    // ---------------------------------------------------------------
    // Handshake and execution
    // ---------------------------------------------------------------
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= IDLE;
            cnt_q <= 4'h0;
            sum_q <= 8'h00;
            exec_q <= 8'h00;
            hold_q <= 1'b0;
            cmd_valid_q <= 1'b0;
            cmd_op_q <= DHCP_OP_NONE;
            cmd_lba_q <= 24'h000000;
            cmd_instr_q <= 8'h00;
        end else begin
            cmd_valid_q <= 1'b0;
            case (state_q)
                IDLE: begin
                    // A new command always starts from an empty buffer and a clear sum.
                    if (link.host_attention) begin
                        state_q <= RECV;
                        cnt_q <= 4'h0;
                        sum_q <= 8'h00;
                    end
                end
                RECV: begin
                    if (byte_take) begin
                        cnt_q <= cnt_q + 4'h1;
                        sum_q <= sum_q + link.host_data;
                    end
                    // The host sees hold-off one cycle after attention falls and must not start before.
                    if (frame_end) begin
                        state_q <= EXEC;
                        hold_q <= 1'b1;
                        exec_q <= EXEC_CYC;
                        cmd_valid_q <= 1'b1;
                        cmd_op_q <= op_d;
                        cmd_lba_q <= legacy_lba;
                        cmd_instr_q <= sys_instr;
                    end
                end
                default: begin
                    // Busy until the result may be read.
                    if (exec_done) begin
                        hold_q <= 1'b0;
                        state_q <= IDLE;
                    end else begin
                        exec_q <= exec_q - 8'h01;
                    end
                end
            endcase
        end
    end
    // ---------------------------------------------------------------
    // Return path and parity
    // ---------------------------------------------------------------
    // Host words are never checked: parity of the echoed word is recomputed here.
    // The direction is taken at the same edge as the word, so on reads the parity on the line
    // belongs to the word beside it; the host reads one cycle after its strobe for that reason.
    wire [7:0] tx_word = link.read_not_write ? result_byte : link.host_data;
    wire tx_parity = ~(^tx_word);
    wire rd_take = rd_stb & ~hold_q;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_data_q <= 8'h00;
            ctrl_oe_q <= 1'b0;
            parity_q <= 1'b1;
            result_rd_q <= 1'b0;
        end else begin
            ctrl_data_q <= result_byte;
            // The controller only drives the bus on reads and never while it is busy.
            ctrl_oe_q <= link.read_not_write & ~hold_q;
            parity_q <= tx_parity;
            result_rd_q <= rd_take;
        end
    end
    assign link.ctrl_data = ctrl_data_q;
    assign link.ctrl_data_oe = ctrl_oe_q;
    assign link.parity = parity_q;
    assign link.controller_hold_off = hold_q;
endmodule : dhcp_device

/* core/dhcp_host.sv */
`timescale 1ns/1ps
module dhcp_host
    import dhcp_pkg::*;
(
    input wire logic mclk,
    input wire logic arst_n,
    dhcp_if.host link,
    input wire logic wr_req,
    input wire logic [7:0] wr_byte,
    input wire logic wr_last,
    input wire logic rd_req,
    output logic ready_q,
    output logic [7:0] rd_byte_q,
    output logic rd_valid_q,
    output logic parity_err_q,
    output logic timeout_q
);
    typedef enum logic [1:0] {H_IDLE, H_HOST_DATA_VALID, H_GAP, H_RSTRB} dhcp_hstate_t;
    dhcp_hstate_t st_q;
    logic [7:0] data_q;
    logic oe_q;
    logic att_q;
    logic host_data_valid_q;
    logic rnw_q;
    logic last_q;
    logic [7:0] wd_q;
    // ---------------------------------------------------------------
    // Bus sequencing
    // ---------------------------------------------------------------
    wire blocked = link.controller_hold_off;
    wire par_bad = ~(^{link.ctrl_data, link.parity});
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= H_IDLE;
            data_q <= 8'h00;
            oe_q <= 1'b0;
            att_q <= 1'b0;
            host_data_valid_q <= 1'b0;
            rnw_q <= 1'b0;
            last_q <= 1'b0;
            wd_q <= 8'h00;
            ready_q <= 1'b0;
            rd_byte_q <= 8'h00;
            rd_valid_q <= 1'b0;
            parity_err_q <= 1'b0;
            timeout_q <= 1'b0;
        end else begin
            rd_valid_q <= 1'b0;
            parity_err_q <= 1'b0;
            timeout_q <= 1'b0;
            ready_q <= (st_q == H_IDLE) & ~blocked;
            // A stuck controller is reported on timeout_q while the host keeps waiting on it.
            if (blocked && st_q == H_IDLE) begin
                wd_q <= wd_q + 8'h01;
                timeout_q <= (wd_q == WATCHDOG_CYC);
            end else begin
                wd_q <= 8'h00;
            end
            case (st_q)
                H_IDLE: begin
                    if (wr_req && !blocked) begin
                        att_q <= 1'b1;
                        data_q <= wr_byte;
                        oe_q <= 1'b1;
                        rnw_q <= 1'b0;
                        last_q <= wr_last;
                        st_q <= H_HOST_DATA_VALID;
                        ready_q <= 1'b0;
                    end else if (rd_req && !blocked) begin
                        rnw_q <= 1'b1;
                        oe_q <= 1'b0;
                        st_q <= H_RSTRB;
                        ready_q <= 1'b0;
                    end
                end
                H_HOST_DATA_VALID: begin
                    host_data_valid_q <= 1'b1;
                    st_q <= H_GAP;
                end
                H_GAP: begin
                    host_data_valid_q <= 1'b0;
                    oe_q <= 1'b0;
                    rnw_q <= 1'b0;
                    if (last_q) begin
                        att_q <= 1'b0;
                    end
                    // Read data is taken a cycle after the strobe, when the controller's word and its
                    // parity both reflect the read direction.
                    if (rnw_q) begin
                        rd_byte_q <= link.ctrl_data;
                        rd_valid_q <= 1'b1;
                        parity_err_q <= par_bad;
                    end
                    st_q <= H_IDLE;
                end
                default: begin
                    host_data_valid_q <= 1'b1;
                    st_q <= H_GAP;
                end
            endcase
        end
    end
    assign link.host_data = data_q;
    assign link.host_data_oe = oe_q;
    assign link.host_attention = att_q;
    assign link.host_data_valid = host_data_valid_q;
    assign link.read_not_write = rnw_q;
endmodule : dhcp_host

/* bench/dhcp_assertions.sv */
`timescale 1ns/1ps
module dhcp_assertions (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic [7:0] host_data,
    input wire logic host_data_oe,
    input wire logic [7:0] ctrl_data,
    input wire logic ctrl_data_oe,
    input wire logic parity,
    input wire logic host_attention,
    input wire logic controller_hold_off,
    input wire logic host_data_valid,
    input wire logic read_not_write
);
    // ---------------------------------------------------------------
    // Link checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);
    wire rd_stb = host_data_valid && read_not_write;
    wire wr_stb = host_data_valid && !read_not_write;
    property p_rd_parity;
        rd_stb |-> ##[0:2] (ctrl_data_oe && parity == ~^ctrl_data);
    endproperty
    a_rd_parity: assert property (p_rd_parity) else $error("bad parity on read");
    property p_wr_parity;
        wr_stb |-> ##[0:2] (parity == ~^host_data);
    endproperty
    a_wr_parity: assert property (p_wr_parity) else $error("parity not regenerated");
    property p_attn_wait;
        $rose(host_attention) |-> !$past(controller_hold_off);
    endproperty
    a_attn_wait: assert property (p_attn_wait) else $error("attention while held off");
    property p_stb_idle;
        host_data_valid |-> !controller_hold_off;
    endproperty
    a_stb_idle: assert property (p_stb_idle) else $error("strobe while held off");
    property p_busy_rise;
        $fell(host_attention) |=> controller_hold_off;
    endproperty
    a_busy_rise: assert property (p_busy_rise) else $error("no hold-off after command");
    // The execution span is short on purpose, so the window is tight.
    property p_busy_hold;
        $rose(controller_hold_off) |-> controller_hold_off[*8] ##[2:4] !controller_hold_off;
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("hold-off span wrong");
    property p_stb_pulse;
        host_data_valid |=> !host_data_valid;
    endproperty
    a_stb_pulse: assert property (p_stb_pulse) else $error("strobe too long");
    property p_wr_driven;
        wr_stb |-> host_data_oe && host_attention;
    endproperty
    a_wr_driven: assert property (p_wr_driven) else $error("write strobe undriven");
    c_read: cover property (rd_stb);
    c_write: cover property (wr_stb);
    c_busy: cover property ($rose(controller_hold_off));
endmodule : dhcp_assertions

/* bench/testbench.sv */
`timescale 1ns/1ps
module testbench;
    import dhcp_pkg::*;
    // ---------------------------------------------------------------
    // Harness
    // ---------------------------------------------------------------
    logic mclk = 1'b0, arst_n = 1'b0, stf = 1'b0, wr_req = 1'b0, wr_last = 1'b0, rd_req = 1'b0;
    logic [7:0] wr_byte = 8'h00, res = 8'h00, rdb, ci;
    logic [7:0] q[$];
    logic ready, rdv, cv, perr, rrd;
    logic [23:0] lba, la;
    dhcp_op_t op;
    int fails = 0, comparisons = 0;
    logic [31:0] seed = 32'h4333;
    dhcp_if link();
    dhcp_device dhcp_device_inst(.mclk(mclk), .arst_n(arst_n), .link(link), .self_test_fail(stf),
        .result_byte(res), .cmd_valid_q(cv), .cmd_op_q(op), .cmd_lba_q(lba), .cmd_instr_q(ci), .result_rd_q(rrd));
    dhcp_host dhcp_host_inst(.mclk(mclk), .arst_n(arst_n), .link(link), .wr_req(wr_req), .wr_byte(wr_byte),
        .wr_last(wr_last), .rd_req(rd_req), .ready_q(ready), .rd_byte_q(rdb), .rd_valid_q(rdv),
        .parity_err_q(perr), .timeout_q());
    dhcp_assertions dhcp_assertions_inst(.mclk(mclk), .arst_n(arst_n), .host_data(link.host_data),
        .host_data_oe(link.host_data_oe), .ctrl_data(link.ctrl_data), .ctrl_data_oe(link.ctrl_data_oe),
        .parity(link.parity), .host_attention(link.host_attention),
        .controller_hold_off(link.controller_hold_off), .host_data_valid(link.host_data_valid),
        .read_not_write(link.read_not_write));
    always #5 mclk = ~mclk;
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    // A whole command sums to all ones when its check byte is right.
    function automatic dhcp_op_t exp_op();
        logic [7:0] s = 8'h00;
        if (q[0] <= 8'h02) begin
            if (stf) return DHCP_OP_REJECT;
            if (q[0] == OP_READ && {q[1], q[2], q[3]} == LBA_IDENT) return DHCP_OP_IDENT;
            if (q[0] == OP_READ && {q[1], q[2], q[3]} == LBA_SPARE) return DHCP_OP_SPARE;
            return dhcp_op_t'(3'(q[0]) + 3'h1);
        end
        foreach (q[k]) s += q[k];
        if (s != 8'hff) return DHCP_OP_REJECT;
        if (q[0][7:4] == TYPE_DIAG) return DHCP_OP_DIAG;
        if (q[0][7:4] != TYPE_SYS || stf) return DHCP_OP_REJECT;
        return dhcp_op_t'(3'(q[1]) + 3'h1);
    endfunction : exp_op
    task automatic chk(string n, logic [31:0] e, logic [31:0] s);
        comparisons++;
        if (s !== e) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic wait_hi(ref logic s, input string n);
        int i = 0;
        #1;
        while (s !== 1'b1 && i < 300) begin
            @(posedge mclk);
            #1;
            i++;
        end
        if (i == 300) chk(n, 1, 0);
    endtask : wait_hi
    task automatic frame(logic [3:0] t, logic [7:0] ins, int np, logic bad);
        logic [7:0] s = 8'h00;
        q = {};
        q.push_back({t, 4'(rnd())});
        q.push_back(ins);
        repeat (np) q.push_back(8'(rnd()));
        foreach (q[k]) s += q[k];
        q.push_back(~s ^ {7'h00, bad});
    endtask : frame
    task automatic test_done();
        if (fails == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : test_done
    initial begin
        #500000;
        fails++;
        test_done();
    end
    initial begin
        dhcp_op_t e;
        int kind;
        repeat (8) @(posedge mclk);
        arst_n <= 1'b1;
        for (int n = 0; n < 48; n++) begin
            @(posedge mclk);
            stf <= (n % 8 >= 6);
            res <= 8'(rnd());
            kind = (n < 4) ? n : int'(rnd() % 4);
            @(posedge mclk);
            if (kind == 0) begin
                q = {8'(n % 3)};
                la = (n == 0) ? LBA_IDENT : ((n % 5 == 1) ? LBA_SPARE : 24'(rnd()));
                q.push_back(la[23:16]);
                q.push_back(la[15:8]);
                q.push_back(la[7:0]);
                repeat (rnd() % 4) q.push_back(8'(rnd()));
            end
            else if (kind == 3) frame(4'(3 + rnd() % 13), 8'h00, 1, 1'b0);
            else frame((kind == 1) ? TYPE_SYS : TYPE_DIAG, 8'(rnd() % 3), int'(rnd() % 12), n == 1);
            e = exp_op();
            for (int k = 0; k < q.size(); k++) begin
                wait_hi(ready, "ready");
                @(posedge mclk);
                wr_req <= 1'b1;
                wr_byte <= q[k];
                wr_last <= (k == q.size() - 1);
                @(posedge mclk);
                wr_req <= 1'b0;
                repeat (3) @(posedge mclk);
            end
            wait_hi(cv, "cmd_valid");
            chk("cmd_op", e, op);
            if (e inside {DHCP_OP_READ, DHCP_OP_WRITE, DHCP_OP_WRVER} && kind == 0) chk("cmd_lba", {q[1], q[2], q[3]}, lba);
            if (kind != 0 && e != DHCP_OP_REJECT) chk("cmd_instr", q[1], ci);
            repeat (2) @(posedge mclk);
            wait_hi(ready, "ready");
            @(posedge mclk);
            rd_req <= 1'b1;
            @(posedge mclk);
            rd_req <= 1'b0;
            wait_hi(rdv, "rd_valid");
            chk("rd_byte", res, rdb);
            chk("parity_err", 0, perr);
            chk("result_rd", 1, rrd);
        end
        test_done();
    end
endmodule : testbench
